// ---- hw/csa_pkg.sv ----
`default_nettype none
package csa_pkg;
   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam logic [31:0] BOOT_NORMAL_ADDR = 32'hffe00000; // Monitor image
   localparam logic [31:0] BOOT_ALT_ADDR    = 32'hfff00000; // Upper flash half
   localparam logic [31:0] VECTOR_BYTES     = 32'h00000008; // Stack and program counter
   localparam logic [31:0] FLASH_MASK_RST   = 32'hffe00000; // Flash base after reset
   localparam logic [31:0] FLASH_SIZE_MASK  = 32'h001fffff; // 2 MB flash
   localparam logic [31:0] ENET_BASE        = 32'h30000000; // Ethernet window base
   localparam logic [31:0] ENET_SIZE_MASK   = 32'h0007ffff; // Ethernet window size
   localparam logic [31:0] SDRAM_SIZE_MASK  = 32'h007fffff; // 8 MB SDRAM at zero
   // ---------------------------------------------------------------
   // Wait states and widths
   // ---------------------------------------------------------------
   localparam int          WAIT_W           = 4;            // Wait count width
   localparam logic [3:0]  FLASH_WAIT_RST   = 4'hf;         // Slowest until programmed
   localparam int          SDRAM_DATA_W     = 16;           // SDRAM data path width
   // Bus cycle states
   typedef enum logic [1:0] {CSA_IDLE, CSA_WAIT, CSA_DONE} csa_state_t;
endpackage
`default_nettype wire

// ---- hw/csa_select_ack.sv ----
// How it works
// - Flash answers vector fetch at address zero
// - Select zero global until mask written
// - Cycle runs from select to acknowledge
// - Acknowledge internal or from addressed device
// - Internal acknowledge after programmed wait states
// - Single SDRAM bank, 16-bit data path
// - Jumper picks normal or alternate boot
// - Ethernet select on asynchronous controller
`timescale 1ns/1ns
`default_nettype none
module csa_select_ack #(
   parameter int WAIT_W = csa_pkg::WAIT_W
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // Processor bus request
   input  wire logic              bus_req,
   input  wire logic [31:0]       bus_addr,
   // Select zero setup (mask write strobe and fields)
   input  wire logic              mask_write,
   input  wire logic [31:0]       mask_base,
   input  wire logic              mask_valid,
   input  wire logic              auto_ack_mode,
   input  wire logic [WAIT_W-1:0] flash_wait,
   // Ethernet select setup
   input  wire logic              enet_auto_ack,
   input  wire logic [WAIT_W-1:0] enet_wait,
   // Boot image jumper
   input  wire logic              boot_image_jumper,
   // External shared acknowledge, active low
   input  wire logic              ext_ack_n,
   // Pins out
   output logic                   boot_select_zero_n,
   output logic                   ethernet_select_n,
   output logic                   sdram_select_n,
   output logic                   transfer_ack,
   output logic                   boot_global,
   output logic [31:0]            boot_vector_base,
   output logic [3:0]             sdram_data_width
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   csa_pkg::csa_state_t state;        // Bus cycle state
   logic                global_mode;  // Select zero answers all addresses
   logic [31:0]         zero_base;    // Programmed flash base
   logic                zero_valid;   // Programmed region enabled
   logic                zero_auto;    // Auto acknowledge for flash
   logic [WAIT_W-1:0]   zero_wait;    // Flash wait states
   logic                hit0;         // Decoded select zero
   logic                hit1;         // Decoded Ethernet select
   logic                hit_sd;       // Decoded SDRAM
   logic                ext_ack_q;    // Registered external ack
   logic                cnt_done;     // Wait states elapsed
   logic                use_auto;     // Current cycle auto-acked
   logic [WAIT_W-1:0]   cur_wait;     // Wait count of current cycle
   logic                start;        // First cycle of bus cycle
   logic                ack_now;      // Acknowledge this cycle

   // Region test with size mask
   function automatic logic in_region(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
      in_region = ((a & ~m) == (b & ~m));
   endfunction

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Global mode lets the flash answer the vector fetch at zero
   assign hit0   = global_mode || (zero_valid && in_region(bus_addr, zero_base, csa_pkg::FLASH_SIZE_MASK));
   assign hit1   = !global_mode && in_region(bus_addr, csa_pkg::ENET_BASE, csa_pkg::ENET_SIZE_MASK);
   assign hit_sd = !global_mode && !hit0 && in_region(bus_addr, 32'h00000000, csa_pkg::SDRAM_SIZE_MASK);
   assign start  = (state == csa_pkg::CSA_IDLE) && bus_req;
   // Ethernet is asynchronous; it normally supplies its own ack
   assign use_auto = hit1 ? enet_auto_ack : (hit0 ? zero_auto : 1'b0);
   assign cur_wait = hit1 ? enet_wait : zero_wait;
   // Either source ends the cycle; external wins equally
   assign ack_now  = (state == csa_pkg::CSA_WAIT) && ((use_auto && cnt_done) || ext_ack_q);

   // ---------------------------------------------------------------
   // Wait counter
   // ---------------------------------------------------------------
   csa_wait_counter #(.WAIT_W(WAIT_W)) u_wait (
      .clock       (clock),
      .reset_n     (reset_n),
      .start       (start),
      .active      (state == csa_pkg::CSA_WAIT),
      .wait_states (cur_wait),
      .done        (cnt_done)
   );

   // ---------------------------------------------------------------
   // Select zero configuration
   // ---------------------------------------------------------------
   // Reset values keep flash slow and global until software writes
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         global_mode <= 1'b1;
         zero_base   <= csa_pkg::FLASH_MASK_RST;
         zero_valid  <= 1'b0;
         zero_auto   <= 1'b1;
         zero_wait   <= WAIT_W'(csa_pkg::FLASH_WAIT_RST);
      end else if (mask_write) begin
         global_mode <= 1'b0;
         zero_base   <= mask_base;
         zero_valid  <= mask_valid;
         zero_auto   <= auto_ack_mode;
         zero_wait   <= flash_wait;
      end
   end

   // ---------------------------------------------------------------
   // External acknowledge sampling
   // ---------------------------------------------------------------
   // Shared line is only ever pulled low by boards
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ext_ack_q <= 1'b0;
      end else begin
         ext_ack_q <= !ext_ack_n;
      end
   end

   // ---------------------------------------------------------------
   // Bus cycle sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= csa_pkg::CSA_IDLE;
      end else begin
         unique case (state)
            csa_pkg::CSA_IDLE: begin
               if (bus_req) begin
                  state <= csa_pkg::CSA_WAIT;
               end
            end
            csa_pkg::CSA_WAIT: begin
               // Hold until some acknowledge arrives
               if (ack_now) begin
                  state <= csa_pkg::CSA_DONE;
               end
            end
            csa_pkg::CSA_DONE: begin
               state <= csa_pkg::CSA_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin outputs, all registered
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         boot_select_zero_n <= 1'b1;
         ethernet_select_n  <= 1'b1;
         sdram_select_n     <= 1'b1;
      end else if (start) begin
         boot_select_zero_n <= !hit0;
         ethernet_select_n  <= !hit1;
         sdram_select_n     <= !hit_sd;
      end else if (ack_now || state == csa_pkg::CSA_IDLE) begin
         boot_select_zero_n <= 1'b1;
         ethernet_select_n  <= 1'b1;
         sdram_select_n     <= 1'b1;
      end
   end

   // Acknowledge pulse to the processor core
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         transfer_ack <= 1'b0;
      end else begin
         transfer_ack <= ack_now;
      end
   end

   // Boot image and static board info
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         boot_vector_base <= csa_pkg::BOOT_NORMAL_ADDR;
         boot_global      <= 1'b1;
         sdram_data_width <= 4'h0;
      end else begin
         boot_vector_base <= boot_image_jumper ? csa_pkg::BOOT_ALT_ADDR : csa_pkg::BOOT_NORMAL_ADDR;
         boot_global      <= global_mode;
         sdram_data_width <= 4'(csa_pkg::SDRAM_DATA_W / 4);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   global_select_a: assert property (
      @(posedge clock) disable iff (!reset_n) (start && global_mode) |=> !boot_select_zero_n)
      else $error("select zero not global");
   vector_fetch_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (start && global_mode && bus_addr < csa_pkg::VECTOR_BYTES) |=> !boot_select_zero_n)
      else $error("vector fetch missed flash");
   ack_needs_wait_a: assert property (
      @(posedge clock) disable iff (!reset_n) transfer_ack |-> $past(state) == csa_pkg::CSA_WAIT)
      else $error("ack outside cycle");
   mask_clears_a: assert property (
      @(posedge clock) disable iff (!reset_n) mask_write |=> !global_mode)
      else $error("mask write kept global");
   ext_ack_ends_a: assert property (
      @(posedge clock) disable iff (!reset_n) (state == csa_pkg::CSA_WAIT && ext_ack_q) |=> transfer_ack)
      else $error("external ack lost");
   // Zero waits: ack registered one edge after the select goes low
   zero_wait_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (start && hit0 && zero_auto && zero_wait == '0) |=> ##1 transfer_ack)
      else $error("zero wait ack late");
   wait_count_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (start && hit0 && zero_auto && zero_wait == 4'h6 && ext_ack_n) ##1 (ext_ack_n && !ext_ack_q)[*7]
      |=> transfer_ack)
      else $error("six wait ack wrong");
   enet_select_a: assert property (
      @(posedge clock) disable iff (!reset_n) (start && hit1) |=> !ethernet_select_n && boot_select_zero_n)
      else $error("ethernet select");
   boot_image_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      boot_image_jumper ##1 boot_image_jumper |-> boot_vector_base == csa_pkg::BOOT_ALT_ADDR)
      else $error("boot image wrong");
endmodule
`default_nettype wire

// ---- hw/csa_wait_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
module csa_wait_counter #(
   parameter int WAIT_W = 4
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // Count control
   input  wire logic              start,
   input  wire logic              active,
   input  wire logic [WAIT_W-1:0] wait_states,
   // Result
   output logic                   done
);
   logic [WAIT_W-1:0] count; // Bus clocks since select

   // ---------------------------------------------------------------
   // Counter: cleared at cycle start, advances while active until it reaches the wait count
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count <= '0;
      end else if (start) begin
         count <= '0;
      end else if (active && count != wait_states) begin
         count <= count + 1'b1;
      end
   end

   // Done once programmed count reached
   assign done = active && !start && (count == wait_states);
endmodule
`default_nettype wire

// ---- tb/csa_ext_device.sv ----
`timescale 1ns/1ns
`default_nettype none
// Slave that returns its own acknowledge
module csa_ext_device (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Select and setup
   input  wire logic       select_n,
   input  wire logic       enable,
   input  wire logic [3:0] delay,
   // Open-collector acknowledge
   output logic            ack_n
);
   logic [4:0] count; // Cycles since select fell
   // ------------------------------
   // Access timer
   // ------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n || select_n) begin
         count <= 5'h00;
      end else if (count != 5'h1f) begin
         count <= count + 5'h01;
      end
   end
   // Pulls low only; released line is the board pull-up
   assign ack_n = !(enable && !select_n && count >= {1'b0, delay});
endmodule
`default_nettype wire

// ---- tb/tb_chip_select_ack_wait_logic.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_chip_select_ack_wait_logic;
   logic        clock = 0, reset_n = 0, bus_req = 0, mask_write = 0; // Drives
   logic        mask_valid = 0, auto_ack_mode = 0, enet_auto_ack = 0;
   logic        boot_image_jumper = 0, dev_en = 0;
   logic [31:0] bus_addr = 0, mask_base = 0;
   logic [3:0]  flash_wait = 0, enet_wait = 0, dev_delay = 0;
   logic        sel0_n, eth_n, sd_n, ack, glob, ext_ack_n, dev_sel_n; // Seen
   logic [31:0] vbase;
   logic [3:0]  width;
   logic [2:0]  sels;     // Selects in first cycle
   logic        done_sel; // Selects at acknowledge
   int          err_count = 0, tests_run = 0, lat, i;
   // ------------------------------
   // Clock and partner
   // ------------------------------
   always #20 clock = ~clock;
   // Slave answers whichever select is active
   assign dev_sel_n = sel0_n & eth_n & sd_n;
   csa_ext_device dev (.clock(clock), .reset_n(reset_n), .select_n(dev_sel_n),
      .enable(dev_en), .delay(dev_delay), .ack_n(ext_ack_n));
   csa_select_ack #(.WAIT_W(4)) DUT (.clock(clock), .reset_n(reset_n), .bus_req(bus_req),
      .bus_addr(bus_addr), .mask_write(mask_write), .mask_base(mask_base),
      .mask_valid(mask_valid), .auto_ack_mode(auto_ack_mode), .flash_wait(flash_wait),
      .enet_auto_ack(enet_auto_ack), .enet_wait(enet_wait),
      .boot_image_jumper(boot_image_jumper), .ext_ack_n(ext_ack_n),
      .boot_select_zero_n(sel0_n), .ethernet_select_n(eth_n), .sdram_select_n(sd_n),
      .transfer_ack(ack), .boot_global(glob), .boot_vector_base(vbase),
      .sdram_data_width(width));
   // ------------------------------
   // Tasks
   // ------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task results;
      if (err_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One bus cycle; request held until acknowledge is seen
   task access(input logic [31:0] a);
      @(posedge clock);
      bus_req <= 1'b1;
      bus_addr <= a;
      @(posedge clock);
      #1;
      // Selects are low from the taking edge; a zero-wait ack drops them one edge later
      sels = {sel0_n, eth_n, sd_n};
      lat = 0;
      while (lat < 40 && ack !== 1'b1) begin
         @(posedge clock);
         #1;
         lat++;
      end
      done_sel = sel0_n & eth_n & sd_n;
      @(posedge clock);
      bus_req <= 1'b0;
   endtask
   // Mask write ends global mode
   task set_flash(input logic [3:0] w, input logic auto);
      @(posedge clock);
      {mask_write, mask_valid, auto_ack_mode, flash_wait} <= {2'b11, auto, w};
      mask_base <= csa_pkg::FLASH_MASK_RST;
      @(posedge clock);
      mask_write <= 1'b0;
   endtask
   task do_reset(input logic jump);
      @(posedge clock);
      reset_n <= 1'b0;
      boot_image_jumper <= jump;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1;
   endtask
   function automatic logic [31:0] flash_addr;
      return csa_pkg::FLASH_MASK_RST | ($urandom & csa_pkg::FLASH_SIZE_MASK);
   endfunction
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      void'($urandom(85581));
      do_reset(1'b0);
      check(glob, 1);
      check(vbase, csa_pkg::BOOT_NORMAL_ADDR);
      check(width, 4'h4);
      check({sel0_n, eth_n, sd_n, ack}, 4'he);
      // Global mode: vectors, Ethernet window, random; slowest wait
      for (i = 0; i < 4; i++) begin
         access(i == 0 ? 32'h0 : i == 1 ? 32'h4 : i == 2 ? csa_pkg::ENET_BASE : $urandom);
         check(lat, 32'(csa_pkg::FLASH_WAIT_RST) + 1);
         check(sels, 3'b011);
         check(done_sel, 1);
      end
      // Flash wait boundaries, six, and a random one
      for (i = 0; i < 4; i++) begin
         set_flash(i == 0 ? 4'h0 : i == 1 ? 4'h6 : i == 2 ? 4'hf : 4'($urandom), 1'b1);
         access(flash_addr());
         check(glob, 0);
         check(lat, 32'(flash_wait) + 1);
         check(sels, 3'b011);
      end
      // Flash without auto mode waits for the slave
      dev_en <= 1'b1;
      dev_delay <= 4'($urandom);
      set_flash(4'h2, 1'b0);
      access(flash_addr());
      // Slave delay, one sample flop, then the registered ack
      check(lat, 32'(dev_delay) + 2);
      // Ethernet: alternate internal and slave acknowledge
      for (i = 0; i < 6; i++) begin
         enet_auto_ack <= i[0];
         enet_wait <= 4'($urandom);
         dev_en <= !i[0];
         dev_delay <= 4'($urandom);
         access(csa_pkg::ENET_BASE | ($urandom & csa_pkg::ENET_SIZE_MASK));
         check(sels, 3'b101);
         if (i[0]) check(lat, 32'(enet_wait) + 1);
         else check(lat, 32'(dev_delay) + 2);
      end
      // SDRAM below the flash; select and slave latency are both checked
      dev_en <= 1'b1;
      access($urandom & csa_pkg::SDRAM_SIZE_MASK);
      check(sels, 3'b110);
      check(lat < 40, 1);
      check(lat, 32'(dev_delay) + 2);
      // Alternate boot image
      do_reset(1'b1);
      check(vbase, csa_pkg::BOOT_ALT_ADDR);
      check(glob, 1);
      results();
   end
   // Hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      results();
   end
endmodule
`default_nettype wire
